// >>> dv/sesp_host_model.sv
/* spi host model in mode 0 that frames commands toward the block.
   assumes the bench calls xfer from one process at a time. */
`timescale 1ns/1ps
module sesp_host_model (
    output logic      link_sclk,
    output logic      link_csn,
    output logic      link_d,
    input  wire logic link_q
);
    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    initial begin
        link_sclk = 1'b0;
        link_csn  = 1'b1;
        link_d    = 1'b0;
    end
    // clock stands still low between frames; 160 ns period inside
    task automatic xfer(input logic [23:0] v, input int n, output logic [15:0] rx);
        rx = 16'h0;
        #37 link_csn = 1'b0;
        for (int i = 0; i < n; i++) begin
            link_d = v[n-1-i];
            #80 link_sclk = 1'b1;
            rx = {rx[14:0], link_q};
            #80 link_sclk = 1'b0;
        end
        #40 link_csn = 1'b1;
        // released line flips so a stale value cannot pass for data
        link_d = ~link_d;
        #400;
    endtask
endmodule

// >>> dv/sesp_status_protect_asserts.sv
/* port assertions for the status and protection block.
   assumes the bind at the foot and mclk as the only sampling clock. */
`timescale 1ns/1ps
module sesp_sp_asserts #(
    parameter int unsigned TW_CYCLES = 20
) (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       link_sclk,
    input wire logic       link_csn,
    input wire logic       link_d,
    input wire logic       write_protect_n,
    input wire logic       array_wr_req,
    input wire logic [9:0] array_wr_addr,
    input wire logic       link_q,
    input wire logic       link_q_oe,
    input wire logic       array_wr_grant,
    input wire logic       array_wr_refuse,
    input wire logic       busy_flag,
    input wire logic       write_enable_latch,
    input wire logic       block_guard_high,
    input wire logic       block_guard_low,
    input wire logic       status_lock_bit,
    input wire logic       hardware_locked_mode
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_no_latch_refuse: assert property (array_wr_req && !write_enable_latch |=>
        array_wr_refuse) else $error("write taken without latch");
    a_one_answer: assert property (array_wr_req |=> array_wr_grant ^ array_wr_refuse)
        else $error("array request not answered once");
    a_quarter_guard: assert property (array_wr_req && block_guard_low &&
        array_wr_addr >= 10'h300 |=> array_wr_refuse) else $error("upper quarter written");
    a_half_guard: assert property (array_wr_req && block_guard_high &&
        array_wr_addr[9] |=> array_wr_refuse) else $error("upper half written");
    a_grant_busy: assert property (array_wr_grant |-> busy_flag)
        else $error("grant without busy");
    a_bits_at_end: assert property ($changed({status_lock_bit, block_guard_high,
        block_guard_low}) |-> busy_flag || $past(busy_flag)) else $error("status bits early");
    a_latch_at_end: assert property ($fell(busy_flag) |-> !write_enable_latch)
        else $error("latch kept after cycle");
    a_lock_enter: assert property ((status_lock_bit && !write_protect_n) [*5] |->
        hardware_locked_mode) else $error("locked mode missed");
    a_lock_leave: assert property (write_protect_n [*5] |-> !hardware_locked_mode)
        else $error("locked mode kept");
    a_lock_needs_bit: assert property (hardware_locked_mode |-> status_lock_bit)
        else $error("locked mode without lock bit");
    a_oe_deselect: assert property (link_csn |-> !link_q_oe)
        else $error("output driven while deselected");

    c_load_done: cover property ($fell(busy_flag) && status_lock_bit);
    c_locked: cover property ($rose(hardware_locked_mode));
    c_grant: cover property (array_wr_grant);
endmodule
bind sesp_status_protect sesp_sp_asserts #(.TW_CYCLES(TW_CYCLES)) u_chk (.mclk, .resetn,
    .link_sclk, .link_csn, .link_d, .write_protect_n, .array_wr_req, .array_wr_addr,
    .link_q, .link_q_oe, .array_wr_grant, .array_wr_refuse, .busy_flag,
    .write_enable_latch, .block_guard_high, .block_guard_low, .status_lock_bit,
    .hardware_locked_mode);

// >>> dv/tb.sv
/* self-checking bench for the status and protection block.
   assumes a shortened self-timed cycle and the host model on the link. */
`timescale 1ns/1ps
module tb;
    import sesp_pkg::*;
    // ------------------------------------------------------------
    // signals, clock, tasks
    // ------------------------------------------------------------
    logic        mclk, resetn, write_protect_n, array_wr_req;
    logic [9:0]  array_wr_addr;
    logic        link_sclk, link_csn, link_d, link_q, link_q_oe;
    logic        array_wr_grant, array_wr_refuse, busy_flag, write_enable_latch;
    logic        block_guard_high, block_guard_low, status_lock_bit, hardware_locked_mode;
    logic [15:0] rx;
    int          failures, comparisons;

    // long enough that a status read fits inside one cycle
    sesp_status_protect #(.TW_CYCLES(100)) DUT (.mclk, .resetn, .link_sclk, .link_csn,
        .link_d, .write_protect_n, .array_wr_req, .array_wr_addr, .link_q, .link_q_oe,
        .array_wr_grant, .array_wr_refuse, .busy_flag, .write_enable_latch,
        .block_guard_high, .block_guard_low, .status_lock_bit, .hardware_locked_mode);
    sesp_host_model host (.link_sclk, .link_csn, .link_d, .link_q);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] st();
        return {status_lock_bit, 3'h0, block_guard_high, block_guard_low,
                write_enable_latch, busy_flag};
    endfunction
    task automatic cmd(input logic [23:0] v, input int n);
        host.xfer(v, n, rx);
        @(posedge mclk);
        #5;
    endtask
    task automatic rd(input logic [7:0] e);
        cmd({SESP_OP_STATUS_READ, 16'h0}, 24);
        chk(rx[15:8], e);
        chk(rx[7:0], e);
    endtask
    task automatic arr(input logic [9:0] a, input logic g);
        array_wr_req = 1'b1;
        array_wr_addr = a;
        @(posedge mclk);
        #5 array_wr_req = 1'b0;
        chk({5'h0, busy_flag, array_wr_grant, array_wr_refuse}, {5'h0, g, g, ~g});
    endtask
    task automatic wait_done();
        for (int i = 0; i < 200 && busy_flag !== 1'b0; i++) @(posedge mclk);
        #5;
    endtask
    task automatic close_out();
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        failures++;
        close_out();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        write_protect_n = 1'b1;
        array_wr_req = 1'b0;
        array_wr_addr = 10'h0;
        repeat (20) @(posedge mclk);
        #5 resetn = 1'b1;
        repeat (4) @(posedge mclk);
        #5;
        rd(8'h00);
        cmd({SESP_OP_SET_LATCH, 1'b0}, 9);
        chk(st(), 8'h00);
        cmd({SESP_OP_STATUS_LOAD, 8'h04}, 16);
        chk(st(), 8'h00);
        cmd(SESP_OP_SET_LATCH, 8);
        rd(8'h02);
        cmd(SESP_OP_CLEAR_LATCH, 8);
        chk(st(), 8'h00);
        cmd({8'hff, SESP_OP_SET_LATCH}, 16);
        chk(st(), 8'h00);
        cmd(SESP_OP_SET_LATCH, 8);
        cmd({SESP_OP_STATUS_LOAD, 7'h7f}, 15);
        chk(st(), 8'h02);
        cmd({SESP_OP_STATUS_LOAD, 8'hff}, 16);
        chk(st(), 8'h03);
        rd(8'h03);
        wait_done();
        chk(st(), 8'h8c);
        cmd(SESP_OP_SET_LATCH, 8);
        arr(10'h000, 1'b0);
        write_protect_n = 1'b0;
        repeat (6) @(posedge mclk);
        #5;
        chk(hardware_locked_mode, 1'b1);
        cmd({SESP_OP_STATUS_LOAD, 8'h00}, 16);
        chk(st(), 8'h8e);
        write_protect_n = 1'b1;
        repeat (6) @(posedge mclk);
        #5;
        chk(hardware_locked_mode, 1'b0);
        cmd({SESP_OP_STATUS_LOAD, 8'h84}, 16);
        wait_done();
        chk(st(), 8'h84);
        cmd(SESP_OP_SET_LATCH, 8);
        arr(10'h2ff, 1'b1);
        wait_done();
        chk(st(), 8'h84);
        cmd(SESP_OP_SET_LATCH, 8);
        arr(10'h300, 1'b0);
        cmd({SESP_OP_STATUS_LOAD, 8'h08}, 16);
        wait_done();
        write_protect_n = 1'b0;
        cmd(SESP_OP_SET_LATCH, 8);
        cmd({SESP_OP_STATUS_LOAD, 8'h04}, 16);
        wait_done();
        chk(st(), 8'h04);
        chk(hardware_locked_mode, 1'b0);
        close_out();
    end
endmodule

// >>> logic/sesp_pkg.sv
/*
 * constants shared by the status and protection block of a serial eeprom:
 * opcodes, status byte layout, reset values, guard limits and timing.
 * assumes a 20 MHz system clock and an spi mode 0 link.
 */
package sesp_pkg;

    // ----------------------------------------------------------------
    // command opcodes, sent msb first
    // ----------------------------------------------------------------
    localparam logic [7:0] SESP_OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] SESP_OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] SESP_OP_STATUS_READ = 8'h05;
    localparam logic [7:0] SESP_OP_STATUS_LOAD = 8'h01;

    // ----------------------------------------------------------------
    // status_control_byte layout
    // ----------------------------------------------------------------
    localparam int SESP_BIT_BUSY  = 0;
    localparam int SESP_BIT_WEL   = 1;
    localparam int SESP_BIT_BP0   = 2;
    localparam int SESP_BIT_BP1   = 3;
    localparam int SESP_BIT_LOCK  = 7;
    localparam logic       SESP_RST_LOCK  = 1'b0;
    localparam logic [1:0] SESP_RST_GUARD = 2'h0;
    localparam logic       SESP_RST_WEL   = 1'b0;

    // ----------------------------------------------------------------
    // block guard encoding and protected address limits
    // ----------------------------------------------------------------
    localparam logic [1:0] SESP_GUARD_NONE    = 2'h0;
    localparam logic [1:0] SESP_GUARD_QUARTER = 2'h1;
    localparam logic [1:0] SESP_GUARD_HALF    = 2'h2;
    localparam logic [1:0] SESP_GUARD_ALL     = 2'h3;
    localparam logic [9:0] SESP_QUARTER_BASE  = 10'h300;
    localparam logic [9:0] SESP_HALF_BASE     = 10'h200;

    // ----------------------------------------------------------------
    // link framing counts
    // ----------------------------------------------------------------
    localparam logic [1:0] SESP_BYTES_ONE = 2'h1;
    localparam logic [1:0] SESP_BYTES_TWO = 2'h2;
    localparam logic [1:0] SESP_BYTES_MAX = 2'h3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SESP_MCLK_PERIOD_NS      = 50;
    localparam int SESP_SELF_TIMED_CYCLE_NS = 1000000;
    localparam int SESP_SELF_TIMED_CYCLES   =
        SESP_SELF_TIMED_CYCLE_NS / SESP_MCLK_PERIOD_NS;

    typedef enum logic [2:0] {
        SESP_ST_IDLE  = 3'b001,
        SESP_ST_LOAD  = 3'b010,
        SESP_ST_ARRAY = 3'b100
    } sesp_state_t;

endpackage

// >>> logic/sesp_status_protect.sv
/*
 * status byte, write enable latch, busy flag and block protection of a
 * serial eeprom, with the spi command decoder for the four status
 * commands. the link side runs on link_sclk; the rest on mclk.
 * assumes spi mode 0, that the array engine asks for write cycles through
 * array_wr_req and that chip select stays high at least four mclk periods.
 */
//
// Overview of operation
// - writes need the latch set by set-latch
// - set-latch acts at deselect, only after exactly one byte
// - clear-latch resets latch at deselect, only after exactly one byte
// - latch clears on reset, clear, load, write
// - status read accepted at any time
// - status byte repeats while selected
// - busy is 1 during write or load
// - latch bit mirrors latch; 0 rejects writes
// - guard bits non-volatile, guard array writes
// - lock with protect low locks status
// - load executes only with exactly 16 bits
// - valid load starts timed cycle, clears latch
// - new status bits appear after cycle ends
// - load keeps b6..b4,b1,b0; b6..b4 read zero
// - lock 0: load allowed when latch set and not busy
// - lock 1, protect high: load still allowed
// - locked mode entered in either event order
// - protect high releases locked mode; so does a load already running when protect fell that ends with lock 0
// - guarded regions refuse writes in both modes
// - msb first, four fixed opcodes
// - unknown opcode waits for deselect
// - guard codes select quarter, half, all
`timescale 1ns/1ps

module sesp_status_protect
    import sesp_pkg::*;
#(
    parameter int unsigned TW_CYCLES = SESP_SELF_TIMED_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       link_sclk,
    input  wire logic       link_csn,
    input  wire logic       link_d,
    input  wire logic       write_protect_n,
    input  wire logic       array_wr_req,
    input  wire logic [9:0] array_wr_addr,
    output logic            link_q,
    output logic            link_q_oe,
    output logic            array_wr_grant,
    output logic            array_wr_refuse,
    output logic            busy_flag,
    output logic            write_enable_latch,
    output logic            block_guard_high,
    output logic            block_guard_low,
    output logic            status_lock_bit,
    output logic            hardware_locked_mode
);

    // ----------------------------------------------------------------
    // link domain: framing and shift in
    // ----------------------------------------------------------------
    logic       fresh_q;
    logic [2:0] phase_q;
    logic [1:0] bytes_q;
    logic [7:0] shift_q;
    logic [7:0] opcode_q;
    logic [7:0] data_q;
    logic [7:0] shift_d;

    assign shift_d = {shift_q[6:0], link_d};

    // set while deselected so the first edge of a frame restarts framing;
    // the clock stands still between frames, so nothing else can do it
    always_ff @(posedge link_sclk or posedge link_csn or negedge resetn) begin
        if (!resetn) begin
            fresh_q <= 1'b1;
        end else if (link_csn) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    always_ff @(posedge link_sclk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= 3'h0;
            bytes_q <= 2'h0;
            shift_q <= 8'h00;
        end else if (fresh_q) begin
            phase_q <= 3'h1;
            bytes_q <= 2'h0;
            shift_q <= {7'h00, link_d};
        end else begin
            phase_q <= phase_q + 3'h1;
            shift_q <= shift_d;
            if (phase_q == 3'h7 && bytes_q != SESP_BYTES_MAX) begin
                bytes_q <= bytes_q + 2'h1;
            end
        end
    end

    // opcode and data byte stay put after deselect until mclk has used them
    always_ff @(posedge link_sclk or negedge resetn) begin
        if (!resetn) begin
            opcode_q <= 8'h00;
            data_q   <= 8'h00;
        end else if (!fresh_q && phase_q == 3'h7) begin
            if (bytes_q == 2'h0) begin
                opcode_q <= shift_d;
            end else if (bytes_q == SESP_BYTES_ONE) begin
                data_q <= shift_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // link domain: status byte crossing and shift out
    // ----------------------------------------------------------------
    logic [7:0] stat_meta_q;
    logic [7:0] stat_sync_q;
    logic [7:0] status_byte_q;
    logic [7:0] tx_q;
    logic       rd_active;

    // per-bit sync; lock, guard and latch bits can change in one mclk cycle, and a byte is snapshotted
    // at each boundary so one read byte is self-consistent
    always_ff @(posedge link_sclk or negedge resetn) begin
        if (!resetn) begin
            stat_meta_q <= 8'h00;
            stat_sync_q <= 8'h00;
        end else begin
            stat_meta_q <= status_byte_q;
            stat_sync_q <= stat_meta_q;
        end
    end

    assign rd_active = !fresh_q && bytes_q != 2'h0 && opcode_q == SESP_OP_STATUS_READ;

    always_ff @(negedge link_sclk or posedge link_csn or negedge resetn) begin
        if (!resetn) begin
            tx_q      <= 8'h00;
            link_q    <= 1'b0;
            link_q_oe <= 1'b0;
        end else if (link_csn) begin
            tx_q      <= 8'h00;
            link_q    <= 1'b0;
            link_q_oe <= 1'b0;
        end else if (rd_active) begin
            link_q_oe <= 1'b1;
            if (phase_q == 3'h0) begin
                tx_q   <= {stat_sync_q[6:0], 1'b0};
                link_q <= stat_sync_q[7];
            end else begin
                tx_q   <= {tx_q[6:0], 1'b0};
                link_q <= tx_q[7];
            end
        end else begin
            link_q_oe <= 1'b0;
            link_q    <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // mclk domain: pin synchronisers and end of frame
    // ----------------------------------------------------------------
    logic       csn_meta_q;
    logic       csn_sync_q;
    logic       csn_prev_q;
    logic       wp_meta_q;
    logic       wp_sync_q;
    logic       frame_end;
    logic       exact_one;
    logic       exact_two;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            csn_meta_q <= 1'b1;
            csn_sync_q <= 1'b1;
            csn_prev_q <= 1'b1;
            wp_meta_q  <= 1'b1;
            wp_sync_q  <= 1'b1;
        end else begin
            csn_meta_q <= link_csn;
            csn_sync_q <= csn_meta_q;
            csn_prev_q <= csn_sync_q;
            wp_meta_q  <= write_protect_n;
            wp_sync_q  <= wp_meta_q;
        end
    end

    // link registers are quiet here: the link clock stops while deselected
    assign frame_end = csn_sync_q && !csn_prev_q;
    assign exact_one = phase_q == 3'h0 && bytes_q == SESP_BYTES_ONE;
    assign exact_two = phase_q == 3'h0 && bytes_q == SESP_BYTES_TWO;

    // ----------------------------------------------------------------
    // mclk domain: protection decisions
    // ----------------------------------------------------------------
    logic [1:0] guard_q;
    logic       lock_q;
    logic       wel_q;
    logic       hw_locked;
    logic       addr_guarded;
    logic       load_ok;
    logic       write_ok;
    sesp_state_t state_q;

    assign hw_locked = lock_q && !wp_sync_q;

    always_comb begin
        unique case (guard_q)
            SESP_GUARD_NONE:    addr_guarded = 1'b0;
            SESP_GUARD_QUARTER: addr_guarded = array_wr_addr >= SESP_QUARTER_BASE;
            SESP_GUARD_HALF:    addr_guarded = array_wr_addr >= SESP_HALF_BASE;
            SESP_GUARD_ALL:     addr_guarded = 1'b1;
        endcase
    end

    assign load_ok = frame_end && exact_two && opcode_q == SESP_OP_STATUS_LOAD
                     && wel_q && !hw_locked && state_q == SESP_ST_IDLE;
    assign write_ok = array_wr_req && wel_q && !addr_guarded && state_q == SESP_ST_IDLE;

    // ----------------------------------------------------------------
    // mclk domain: self-timed cycle
    // ----------------------------------------------------------------
    logic [31:0] tw_cnt_q;
    logic        cycle_done;
    logic [7:0]  pend_q;

    assign cycle_done = state_q != SESP_ST_IDLE && tw_cnt_q == 32'h0;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= SESP_ST_IDLE;
            tw_cnt_q <= 32'h0;
        end else begin
            unique case (state_q)
                SESP_ST_IDLE: begin
                    if (load_ok) begin
                        state_q  <= SESP_ST_LOAD;
                        tw_cnt_q <= TW_CYCLES - 32'h1;
                    end else if (write_ok) begin
                        state_q  <= SESP_ST_ARRAY;
                        tw_cnt_q <= TW_CYCLES - 32'h1;
                    end
                end
                SESP_ST_LOAD, SESP_ST_ARRAY: begin
                    if (tw_cnt_q == 32'h0) begin
                        state_q <= SESP_ST_IDLE;
                    end else begin
                        tw_cnt_q <= tw_cnt_q - 32'h1;
                    end
                end
                default: begin
                    state_q  <= SESP_ST_IDLE;
                    tw_cnt_q <= 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 8'h00;
        end else if (load_ok) begin
            pend_q <= data_q;
        end
    end

    // ----------------------------------------------------------------
    // mclk domain: status bits
    // ----------------------------------------------------------------
    // non-volatile bits held in flops; reset gives the delivery state
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lock_q  <= SESP_RST_LOCK;
            guard_q <= SESP_RST_GUARD;
        end else if (cycle_done && state_q == SESP_ST_LOAD) begin
            lock_q  <= pend_q[SESP_BIT_LOCK];
            guard_q <= {pend_q[SESP_BIT_BP1], pend_q[SESP_BIT_BP0]};
        end
    end

    // clears at the end of a cycle; set-latch cannot land then, as it is
    // refused while busy
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wel_q <= SESP_RST_WEL;
        end else if (cycle_done) begin
            wel_q <= 1'b0;
        end else if (frame_end && exact_one && state_q == SESP_ST_IDLE
                     && opcode_q == SESP_OP_SET_LATCH) begin
            wel_q <= 1'b1;
        end else if (frame_end && exact_one && opcode_q == SESP_OP_CLEAR_LATCH) begin
            wel_q <= 1'b0;
        end
    end

    // b6..b4 always zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status_byte_q <= 8'h00;
        end else begin
            status_byte_q <= {lock_q, 3'h0, guard_q, wel_q,
                              state_q != SESP_ST_IDLE};
        end
    end

    // ----------------------------------------------------------------
    // mclk domain: registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            array_wr_grant       <= 1'b0;
            array_wr_refuse      <= 1'b0;
            busy_flag            <= 1'b0;
            write_enable_latch   <= 1'b0;
            block_guard_high     <= 1'b0;
            block_guard_low      <= 1'b0;
            status_lock_bit      <= 1'b0;
            hardware_locked_mode <= 1'b0;
        end else begin
            array_wr_grant       <= write_ok;
            array_wr_refuse      <= array_wr_req && !write_ok;
            // rises with the grant so busy never lags a started cycle
            busy_flag            <= state_q != SESP_ST_IDLE || load_ok || write_ok;
            write_enable_latch   <= wel_q;
            block_guard_high     <= guard_q[1];
            block_guard_low      <= guard_q[0];
            status_lock_bit      <= lock_q;
            hardware_locked_mode <= hw_locked;
        end
    end

endmodule
